// ### logic/arit_timer.sv
// Eight-bit auto-reload interval timer with prescaler, APB register slave and interrupt.
`timescale 1ns/1ns

// Register map; the byte address on the bus is four times the index:
//   index FFB4  mode register, read and write.
//   index FFB5  reads the counter, writes the reload register.
//   index FFF4  interrupt enable, bit 1, read and write.
//   index FFF7  interrupt request flag, bit 1, read only.
//   index FFF8  interrupt clear, a one written to bit 1 clears the flag.
// A write to the request register, or any access to another index, ends in pslverr.
// The bus answers with no wait states: pready is high in the first access cycle.
//
// Limitations that a user must know:
//   The direction, subclock and event pins pass two flip-flops before any logic
//   reads them, so the counter reacts to a pin some clocks after the pin moves.
//   Event and subclock pulses must stay at least two clocks high and two clocks low.
//   A reload write while counting up changes only the reload register.
//   In auto-reload mode an overflow while counting up also reloads the counter.
//   The interrupt output is a flop fed from the flag's next value and rises in the same clock as the flag.
//   The mode bits 4 and 3 have no function; they are stored and read back.
module arit_timer #(
	parameter int ADDR_W = 18
) (
	// APB clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB request.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	// APB answer.
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Timer pins from outside the clock domain.
	input  wire logic              updown_pin,
	input  wire logic              subclock_pin,
	input  wire logic              event_pin,
	// Processor interrupt mask level, from logic on pclk.
	input  wire logic              interrupt_mask_bit,
	// Interrupt request to the processor.
	output logic                   irq
);
	import arit_pkg::*;

	// Elaboration checks. The index compare needs sixteen index bits above the
	// byte offset, and the tap wiring below is drawn for the package's divider
	// figures; other values would give wrong tick rates without any warning.
	initial begin
		if (ADDR_W < 18) begin
			$error("ADDR_W must be at least 18");
		end
		if (ARIT_PRESC_W != 13) begin
			$error("Prescaler taps are wired for a thirteen-bit prescaler");
		end
		if (ARIT_OSC_DIV != 2) begin
			$error("System clock enable is wired as a divide by two");
		end
		if (ARIT_SUB_DIV != 4) begin
			$error("Subclock divider is wired as a divide by four");
		end
		if (ARIT_IRQ_BIT != 1) begin
			$error("Read words place the interrupt bit at position one");
		end
	end

	// Register state.
	arit_mode_t                  mode_r;
	logic [7:0]                  count_r;
	logic [7:0]                  count_nxt;
	logic [7:0]                  reload_r;
	logic                        flag_r;
	logic                        flag_nxt;
	logic                        irq_en_r;
	logic                        osc_div_r;
	logic [ARIT_PRESC_W-1:0]     presc_r;
	logic [1:0]                  sub_div_r;
	logic [31:0]                 prdata_r;
	logic                        pready_r;
	logic                        pslverr_r;
	logic                        irq_r;

	// Pin synchronisers: the first stage of each pair feeds only the second.
	// The edge history resets low, the idle level of the event and subclock
	// pins, so that no false edge follows the release of reset.
	logic                        ud_s1_r;
	logic                        ud_s2_r;
	logic                        sub_s1_r;
	logic                        sub_s2_r;
	logic                        sub_d_r;
	logic                        ev_s1_r;
	logic                        ev_s2_r;
	logic                        ev_d_r;

	// Bus decode. A setup cycle loads the answer flops; the access cycle in
	// which pready stands is the only cycle in which a write takes effect.
	// Mode, reload and enable writes are blocked while pslverr stands, so a refused transfer changes
	// no register.
	wire [15:0] idx        = paddr[17:2];
	wire        setup      = psel & ~penable;
	wire        access     = psel & penable & pready_r;
	wire        wr         = access & pwrite;
	wire        hit_mode   = (idx == ARIT_IDX_MODE);
	wire        hit_count  = (idx == ARIT_IDX_COUNT);
	wire        hit_en     = (idx == ARIT_IDX_IRQ_EN);
	wire        hit_req    = (idx == ARIT_IDX_IRQ_REQ);
	wire        hit_clr    = (idx == ARIT_IDX_IRQ_CLR);
	wire        mapped     = hit_mode | hit_count | hit_en | hit_req | hit_clr;
	wire        wr_mode    = wr & hit_mode & ~pslverr_r;
	wire        wr_reload  = wr & hit_count & ~pslverr_r;
	wire        wr_en      = wr & hit_en & ~pslverr_r;
	wire        wr_clr     = wr & hit_clr & pwdata[ARIT_IRQ_BIT];

	// Read words of each register; the unused upper bits always read zero.
	wire [31:0] rd_mode  = {24'h000000, mode_r};
	wire [31:0] rd_count = {24'h000000, count_r};
	wire [31:0] rd_en    = {30'h00000000, irq_en_r, 1'h0};
	wire [31:0] rd_req   = {30'h00000000, flag_r, 1'h0};

	// Read mux; the shared address reads the counter, clear register reads zero.
	arit_rsp_t rsp;
	assign rsp.data = hit_mode  ? rd_mode :
	                  hit_count ? rd_count :
	                  hit_en    ? rd_en :
	                  hit_req   ? rd_req :
	                  32'h00000000;
	assign rsp.err  = ~mapped;

	// System clock enable is the oscillator (pclk) divided by two.
	wire sys_en = osc_div_r;

	// Prescaler taps: a tap fires when the low bits below it all read ones.
	// Each tap is a one-cycle enable, high once per period of its divided
	// clock, so every counter source runs on the single pclk.
	wire tap_8192 = sys_en & (&presc_r[12:0]);
	wire tap_2048 = sys_en & (&presc_r[10:0]);
	wire tap_512  = sys_en & (&presc_r[8:0]);
	wire tap_64   = sys_en & (&presc_r[5:0]);
	wire tap_16   = sys_en & (&presc_r[3:0]);
	wire tap_4    = sys_en & (&presc_r[1:0]);

	// Subclock and external event edges, taken from synchronised levels.
	// Every fourth subclock rising edge gives one counter tick.
	wire sub_edge = sub_s2_r & ~sub_d_r;
	wire tap_sub  = sub_edge & (&sub_div_r);
	wire tap_ext  = ev_s2_r & ~ev_d_r;

	// Decode of the clock select field, one wire per counter source.
	wire sel_8192 = (mode_r.clock_select == ARIT_CS_8192);
	wire sel_2048 = (mode_r.clock_select == ARIT_CS_2048);
	wire sel_512  = (mode_r.clock_select == ARIT_CS_512);
	wire sel_64   = (mode_r.clock_select == ARIT_CS_64);
	wire sel_16   = (mode_r.clock_select == ARIT_CS_16);
	wire sel_4    = (mode_r.clock_select == ARIT_CS_4);
	wire sel_sub  = (mode_r.clock_select == ARIT_CS_SUB);
	wire sel_ext  = (mode_r.clock_select == ARIT_CS_EXT);

	// Counter input selection; exactly one select wire is high at a time.
	wire tick = (sel_8192 & tap_8192) | (sel_2048 & tap_2048) |
	            (sel_512 & tap_512) | (sel_64 & tap_64) |
	            (sel_16 & tap_16) | (sel_4 & tap_4) |
	            (sel_sub & tap_sub) | (sel_ext & tap_ext);

	// Direction: software bit unless the pin has control (pin high counts down).
	// When the pin has control the software down bit is ignored altogether.
	wire count_down = mode_r.hw_direction_select ? ud_s2_r
	                                             : mode_r.down_select;
	wire underflow  = tick & count_down & (count_r == 8'h00);
	wire overflow   = tick & ~count_down & (count_r == 8'hFF);
	wire wrap_event = underflow | overflow;

	// Next count: reload write, then wrap handling, then plain step.
	// A reload write while counting down wins over a tick in the same cycle, so
	// software sees its written value as the start of the next count. A wrap in
	// auto-reload mode loads the reload value instead of stepping past zero or past FF;
	// in interval mode the counter simply rolls over.
	always_comb begin
		count_nxt = count_r;
		if (wr_reload & count_down) begin
			count_nxt = pwdata[7:0];
		end else if (wrap_event & mode_r.reload_select) begin
			count_nxt = reload_r;
		end else if (tick & count_down) begin
			count_nxt = 8'(count_r - 8'h01);
		end else if (tick) begin
			count_nxt = 8'(count_r + 8'h01);
		end
	end

	// Flag: a wrap in the same cycle as a clear keeps the flag set.
	// The set wins because losing an event would cost the handler a whole
	// period, while a second read of the flag costs nothing.
	always_comb begin
		flag_nxt = flag_r;
		if (wr_clr) begin
			flag_nxt = 1'b0;
		end
		if (wrap_event) begin
			flag_nxt = 1'b1;
		end
	end

	// Oscillator divider and prescaler. The prescaler runs freely from reset
	// and is never cleared by software, so a new clock select takes effect at
	// the next tap of the free-running count.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_div_r <= 1'b0;
			presc_r   <= '0;
		end else begin
			osc_div_r <= ~osc_div_r;
			if (sys_en) begin
				presc_r <= ARIT_PRESC_W'(presc_r + 1'b1);
			end
		end
	end

	// Subclock pin synchroniser and its edge history.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sub_s1_r <= 1'b0;
			sub_s2_r <= 1'b0;
			sub_d_r  <= 1'b0;
		end else begin
			sub_s1_r <= subclock_pin;
			sub_s2_r <= sub_s1_r;
			sub_d_r  <= sub_s2_r;
		end
	end

	// Event pin synchroniser and its edge history.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_s1_r <= 1'b0;
			ev_s2_r <= 1'b0;
			ev_d_r  <= 1'b0;
		end else begin
			ev_s1_r <= event_pin;
			ev_s2_r <= ev_s1_r;
			ev_d_r  <= ev_s2_r;
		end
	end

	// Direction pin synchroniser and subclock divide-by-four.
	// The direction level is only read from the second stage.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ud_s1_r   <= 1'b0;
			ud_s2_r   <= 1'b0;
			sub_div_r <= 2'h0;
		end else begin
			ud_s1_r <= updown_pin;
			ud_s2_r <= ud_s1_r;
			if (sub_edge) begin
				sub_div_r <= sub_div_r + 2'h1;
			end
		end
	end

	// Software registers: mode, reload value and interrupt enable change only
	// in the access cycle of an accepted write.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r   <= ARIT_MODE_RST;
			reload_r <= ARIT_RELOAD_RST;
			irq_en_r <= 1'b0;
		end else begin
			if (wr_mode) begin
				mode_r <= pwdata[7:0];
			end
			if (wr_reload) begin
				reload_r <= pwdata[7:0];
			end
			if (wr_en) begin
				irq_en_r <= pwdata[ARIT_IRQ_BIT];
			end
		end
	end

	// Counter and interrupt flag, updated every clock from their next values.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= ARIT_COUNT_RST;
			flag_r  <= 1'b0;
		end else begin
			count_r <= count_nxt;
			flag_r  <= flag_nxt;
		end
	end

	// Bus answer flops: ready rises in the access phase, data latched at setup.
	// Latching at setup keeps the read word stable through the whole access
	// cycle even if the counter steps in that cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h00000000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= setup;
			if (setup) begin
				prdata_r  <= pwrite ? 32'h00000000 : rsp.data;
				pslverr_r <= rsp.err | (pwrite & hit_req);
			end
		end
	end

	// Interrupt level: flag, enable and the processor mask, taken from the
	// flag's next value so the request rises together with the flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= flag_nxt & irq_en_r & ~interrupt_mask_bit;
		end
	end

	// Every output comes straight from its flop.
	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign irq     = irq_r;

endmodule

// ### logic/arit_pkg.sv
// Package with register map, field layout and timing constants of the reload timer.
package arit_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [15:0] ARIT_IDX_MODE      = 16'hFFB4;
	localparam logic [15:0] ARIT_IDX_COUNT     = 16'hFFB5;
	localparam logic [15:0] ARIT_IDX_IRQ_EN    = 16'hFFF4;
	localparam logic [15:0] ARIT_IDX_IRQ_REQ   = 16'hFFF7;
	localparam logic [15:0] ARIT_IDX_IRQ_CLR   = 16'hFFF8;

	// Bit position of the timer flag in the enable, request and clear registers.
	localparam int ARIT_IRQ_BIT = 1;

	// Reset values.
	localparam logic [7:0] ARIT_MODE_RST   = 8'h00;
	localparam logic [7:0] ARIT_COUNT_RST  = 8'h00;
	localparam logic [7:0] ARIT_RELOAD_RST = 8'h00;

	// Divider figures.
	localparam int ARIT_OSC_DIV   = 2;
	localparam int ARIT_PRESC_W   = 13;
	localparam int ARIT_SUB_DIV   = 4;

	// Counter input select codes.
	localparam logic [2:0] ARIT_CS_8192 = 3'h0;
	localparam logic [2:0] ARIT_CS_2048 = 3'h1;
	localparam logic [2:0] ARIT_CS_512  = 3'h2;
	localparam logic [2:0] ARIT_CS_64   = 3'h3;
	localparam logic [2:0] ARIT_CS_16   = 3'h4;
	localparam logic [2:0] ARIT_CS_4    = 3'h5;
	localparam logic [2:0] ARIT_CS_SUB  = 3'h6;
	localparam logic [2:0] ARIT_CS_EXT  = 3'h7;

	// Layout of the mode register.
	typedef struct packed {
		logic       reload_select;
		logic       hw_direction_select;
		logic       down_select;
		logic [1:0] spare;
		logic [2:0] clock_select;
	} arit_mode_t;

	// Read answer carried from decode to the bus flops.
	typedef struct packed {
		logic [31:0] data;
		logic        err;
	} arit_rsp_t;

endpackage

// ### bench/arit_cpu_model.sv
// Model of the processor interrupt logic beside the timer.
`timescale 1ns/1ns
module arit_cpu_model (
	// Clock and reset.
	input  wire logic	pclk,
	input  wire logic	presetn,
	// Software mask request and timer request line.
	input  wire logic	mask_req,
	input  wire logic	irq,
	// Mask level and count of accepted request cycles.
	output logic		interrupt_mask_bit,
	output int		taken
);
	// The mask starts set and follows software; requests count only unmasked.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_mask_bit <= 1'b1;
			taken <= 0;
		end else begin
			interrupt_mask_bit <= mask_req;
			taken <= taken + int'(irq && !interrupt_mask_bit);
		end
	end
endmodule

// ### bench/arit_timer_monitor.sv
// Checker of bus answers and interrupt level of the reload timer.
`timescale 1ns/1ns
module arit_timer_monitor import arit_pkg::*; #(
	parameter int ADDR_W = 18
) (
	// Clock and reset.
	input  wire logic		pclk,
	input  wire logic		presetn,
	// Bus.
	input  wire logic		psel,
	input  wire logic		penable,
	input  wire logic		pwrite,
	input  wire logic [ADDR_W-1:0]	paddr,
	input  wire logic [31:0]	pwdata,
	input  wire logic [31:0]	prdata,
	input  wire logic		pready,
	input  wire logic		pslverr,
	// Interrupt.
	input  wire logic		interrupt_mask_bit,
	input  wire logic		irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Decode of the current request.
	wire logic [15:0] idx = paddr[17:2];
	wire logic setup = psel && !penable;
	wire logic done = psel && penable && pready;
	wire logic ro_wr = pwrite && idx == ARIT_IDX_IRQ_REQ;
	wire logic mapped = idx inside {ARIT_IDX_MODE, ARIT_IDX_COUNT, ARIT_IDX_IRQ_EN,
		ARIT_IDX_IRQ_REQ, ARIT_IDX_IRQ_CLR};
	property p_ready; setup |=> pready ##1 !pready; endproperty
	a_ready: assert property (p_ready) else $error("bad ready");
	property p_unmap; setup && !mapped |=> pslverr; endproperty
	a_unmap: assert property (p_unmap) else $error("no error");
	property p_ro; setup && ro_wr |=> pslverr; endproperty
	a_ro: assert property (p_ro) else $error("ro write ok");
	property p_ok; setup && mapped && !ro_wr |=> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("false error");
	property p_upper; done && !pwrite |-> prdata[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper bits");
	sequence s_mode; done && pwrite && idx == ARIT_IDX_MODE; endsequence
	property p_mode; s_mode ##1 setup && !pwrite && idx == ARIT_IDX_MODE
		|=> prdata[7:0] == $past(pwdata[7:0], 2); endproperty
	a_mode: assert property (p_mode) else $error("mode readback");
	property p_mask; interrupt_mask_bit |=> !irq; endproperty
	a_mask: assert property (p_mask) else $error("masked irq");
	property p_hold; irq && !interrupt_mask_bit && !(done && pwrite) |=> irq; endproperty
	a_hold: assert property (p_hold) else $error("irq dropped");
	c_irq: cover property ($rose(irq));
	c_err: cover property (done && pslverr);
	c_cnt: cover property (done && !pwrite && idx == ARIT_IDX_COUNT);
endmodule
bind arit_timer arit_timer_monitor #(.ADDR_W(ADDR_W)) arit_timer_monitor_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.interrupt_mask_bit(interrupt_mask_bit), .irq(irq));

// ### bench/arit_timer_test.sv
// Self-checking bench of the reload timer with an interrupt model.
`timescale 1ns/1ns
module arit_timer_test;
	import arit_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq_d = 0;
	logic updown_pin = 1, event_pin = 0, mask_req = 1, subclock_pin = 0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, irq, interrupt_mask_bit;
	logic [33:0] q[$];
	logic [33:0] e;
	logic [7:0] r;
	int fail_count = 0, compares = 0, cnt = 0, last = 0, gap = 0, taken, t0;
	arit_timer arit_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .updown_pin(updown_pin),
		.subclock_pin(subclock_pin), .event_pin(event_pin),
		.interrupt_mask_bit(interrupt_mask_bit), .irq(irq));
	arit_cpu_model arit_cpu_model_inst (.pclk(pclk), .presetn(presetn),
		.mask_req(mask_req), .irq(irq), .interrupt_mask_bit(interrupt_mask_bit),
		.taken(taken));
	initial forever #25 pclk = ~pclk;
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic conclude;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// One transfer, left open so that the next setup may follow at once.
	task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] d,
		input logic [33:0] x);
		q.push_back(x);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
	endtask
	task automatic rd(input logic [15:0] i, input logic [7:0] d);
		xfer(1'b0, i, 8'h00, {2'b10, 24'h0, d});
	endtask
	task automatic wr(input logic [15:0] i, input logic [7:0] d);
		xfer(1'b1, i, d, 34'h0);
	endtask
	task automatic cyc(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge pclk);
	endtask
	task automatic ev(input int n, input bit s = 1'b0);
		repeat (n) begin
			if (s) begin
				subclock_pin <= 1'b1;
			end else begin
				event_pin <= 1'b1;
			end
			cyc(4);
			event_pin <= 1'b0;
			subclock_pin <= 1'b0;
			cyc(4);
		end
		cyc(4);
	endtask
	task automatic till(input logic v);
		cyc(1);
		while (irq !== v) cyc(1);
	endtask
	// Answers are compared in order against the noted expectations.
	always @(posedge pclk) begin
		cnt <= cnt + 1;
		irq_d <= irq;
		if (irq === 1'b1 && irq_d === 1'b0) begin
			gap <= cnt - last;
			last <= cnt;
		end
		if (psel && penable && pready === 1'b1) begin
			e = q.pop_front();
			chk("pslverr", pslverr, e[32]);
			if (e[33]) chk("prdata", prdata, e[31:0]);
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		conclude();
	end
	initial begin
		void'($urandom(32'h2192));
		r = 8'h3 + 8'($urandom % 4);
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ARIT_IDX_MODE, ARIT_MODE_RST);
		rd(ARIT_IDX_COUNT, ARIT_COUNT_RST);
		wr(ARIT_IDX_MODE, 8'hA7);
		rd(ARIT_IDX_MODE, 8'hA7);
		wr(ARIT_IDX_COUNT, r);
		rd(ARIT_IDX_COUNT, r);
		ev(2);
		rd(ARIT_IDX_COUNT, r - 8'h2);
		wr(ARIT_IDX_MODE, 8'hC7);
		updown_pin <= 1'b0;
		ev(1);
		rd(ARIT_IDX_COUNT, r - 8'h1);
		updown_pin <= 1'b1;
		ev(1);
		rd(ARIT_IDX_COUNT, r - 8'h2);
		wr(ARIT_IDX_MODE, 8'hA7);
		ev(int'(r) - 1);
		rd(ARIT_IDX_COUNT, r);
		rd(ARIT_IDX_IRQ_REQ, 8'h02);
		wr(ARIT_IDX_IRQ_CLR, 8'h02);
		rd(ARIT_IDX_IRQ_REQ, 8'h00);
		wr(ARIT_IDX_MODE, 8'h27);
		wr(ARIT_IDX_COUNT, 8'h00);
		ev(1);
		rd(ARIT_IDX_COUNT, 8'hFF);
		wr(ARIT_IDX_MODE, 8'h06);
		ev(4, 1'b1);
		rd(ARIT_IDX_COUNT, 8'h00);
		xfer(1'b0, 16'h0000, 8'h00, {2'b01, 32'h0});
		xfer(1'b1, ARIT_IDX_IRQ_REQ, 8'h00, {2'b01, 32'h0});
		wr(ARIT_IDX_IRQ_CLR, 8'h02);
		mask_req <= 1'b0;
		wr(ARIT_IDX_IRQ_EN, 8'h02);
		rd(ARIT_IDX_IRQ_EN, 8'h02);
		wr(ARIT_IDX_MODE, 8'hBB);
		wr(ARIT_IDX_COUNT, 8'h02);
		till(1'b1);
		wr(ARIT_IDX_IRQ_CLR, 8'h02);
		till(1'b0);
		till(1'b1);
		cyc(1);
		chk("gap", gap, 3 * ARIT_OSC_DIV * 64);
		mask_req <= 1'b1;
		cyc(2);
		t0 = taken;
		wr(ARIT_IDX_IRQ_CLR, 8'h02);
		cyc(800);
		chk("irq", irq, 1'b0);
		chk("taken", taken, t0);
		mask_req <= 1'b0;
		cyc(3);
		chk("irq", irq, 1'b1);
		conclude();
	end
endmodule
